// ===== include/wit_pkg.sv
// Constants, field layout and carrier types for the watch and interval timer.
// Assumes one system clock that stands for the main clock and a byte-wide CPU port.
package wit_pkg;

	// Control register location and reset value.
	localparam logic [15:0] WATCH_MODE_CONTROL_ADDR  = 16'hFF41;
	localparam logic [7:0]  WATCH_MODE_CONTROL_RESET = 8'h00;

	// Address and data widths of the CPU port.
	localparam int ADDR_WIDTH = 16;
	localparam int DATA_WIDTH = 8;

	// Main clock divider: the watch clock is the main clock over 2^7 or 2^11.
	localparam int DIV_WIDTH     = 11;
	localparam int DIV_FAST_BITS = 7;
	localparam int DIV_SLOW_BITS = 11;

	// Prescaler and watch counter widths.
	localparam int PRESCALER_WIDTH = 9;
	localparam int COUNTER_WIDTH   = 5;

	// Fast-feed flag period is 2^5 watch clock periods.
	localparam int FAST_FEED_BITS = 5;

	// Normal flag period is 2^14 watch clock periods, 0.25 s at 8.38 MHz over 2^7.
	localparam int NORMAL_FLAG_BITS = PRESCALER_WIDTH + COUNTER_WIDTH;

	// Interval code 000 selects 2^4 watch clock periods; codes above 101 are prohibited.
	localparam int         INTERVAL_BASE_BITS = 4;
	localparam logic [2:0] INTERVAL_CODE_MAX  = 3'h5;

	// Watch mode control register layout, bit 7 first.
	typedef struct packed {
		logic       countClockSelect;
		logic [2:0] intervalSelect;
		logic       flagRateSelect;
		logic       reservedZero;
		logic       counterRun;
		logic       timerEnable;
	} wit_ctrl_s;

	// Timer events raised in one cycle.
	typedef struct packed {
		logic watchEvent;
		logic intervalEvent;
	} wit_event_s;

endpackage : wit_pkg

// ===== hw/wit_clock_divider.sv
// Divider that turns the main clock into one-cycle watch clock ticks.
// Assumes clk is the main clock and the select input comes from the same domain.
`timescale 1ns/1ps
module wit_clock_divider
(
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic countClockSelect,
	output logic      fwTick_ff
);

	logic [wit_pkg::DIV_WIDTH-1:0] divCount_ff;
	logic [wit_pkg::DIV_WIDTH-1:0] nxt_divCount;
	logic                          nxt_fwTick;

	// A tick marks the last main clock cycle of each watch clock period.
	always_comb
	begin
		nxt_divCount = divCount_ff + 1'b1;
		if (countClockSelect)
			nxt_fwTick = &divCount_ff[wit_pkg::DIV_SLOW_BITS-1:0];
		else
			nxt_fwTick = &divCount_ff[wit_pkg::DIV_FAST_BITS-1:0];
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			divCount_ff <= '0;
			fwTick_ff   <= 1'b0;
		end
		else
		begin
			divCount_ff <= nxt_divCount;
			fwTick_ff   <= nxt_fwTick;
		end
	end

endmodule : wit_clock_divider

// ===== hw/wit_prescaler.sv
// Nine-bit prescaler counted by watch clock ticks.
// Assumes clear and advance come from logic on the same clock.
`timescale 1ns/1ps
module wit_prescaler
(
	input  wire logic                                 clk,
	input  wire logic                                 srst,
	input  wire logic                                 clear,
	input  wire logic                                 advance,
	output logic [wit_pkg::PRESCALER_WIDTH-1:0]       count_ff
);

	logic [wit_pkg::PRESCALER_WIDTH-1:0] nxt_count;

	// Clear has priority over counting.
	always_comb
	begin
		if (clear)
			nxt_count = '0;
		else if (advance)
			nxt_count = count_ff + 1'b1;
		else
			nxt_count = count_ff;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			count_ff <= '0;
		else
			count_ff <= nxt_count;
	end

endmodule : wit_prescaler

// ===== hw/wit_watch_timer.sv
// Watch and interval timer with its byte-wide mode control register.
// Assumes a synchronous CPU port on clk; clk stands for the main clock.
//
// Behaviour
// - Interval interrupt repeats every selected prescaler interval while enabled.
// - Control register sits at FF41H and reads 00H after reset.
// - Bit 7 selects watch clock: main clock over 2^7 or 2^11.
// - Bits 6..4 select 2^4..2^9 periods; codes 110 and 111 prohibited.
// - Bit 3 selects flag period: 2^14 normal, 2^5 fast-feed.
// - Bit 1 runs the 5-bit counter; zero stops and clears it.
// - Bit 0 enables the timer; zero clears prescaler and counter.
// - Watch counting runs only when bits 0 and 1 are both set.
// - Writing those bits to zero clears the counter and stops counting.
// - Clearing only bit 1 restarts the watch; prescaler keeps running.
// - Normal mode gives a watch period of 2^14 watch clocks; the first one after setting only bit 1 can be shorter.
`timescale 1ns/1ps
module wit_watch_timer
(
	input  wire logic                             clk,
	input  wire logic                             srst,
	input  wire logic [wit_pkg::ADDR_WIDTH-1:0]   cpuAddr,
	input  wire logic                             cpuWrEn,
	input  wire logic [wit_pkg::DATA_WIDTH-1:0]   cpuWrData,
	input  wire logic                             cpuRdEn,
	output logic      [wit_pkg::DATA_WIDTH-1:0]   cpuRdData_ff,
	output logic                                  watchInterrupt_ff,
	output logic                                  intervalInterrupt_ff
);

	// True when the CPU port addresses the control register.
	function automatic logic isCtrlAddr(input logic [wit_pkg::ADDR_WIDTH-1:0] addr);
		isCtrlAddr = (addr == wit_pkg::WATCH_MODE_CONTROL_ADDR);
	endfunction : isCtrlAddr

	// Prescaler tap that closes the selected interval.
	function automatic logic [3:0] intervalTap(input logic [2:0] code);
		intervalTap = 4'(wit_pkg::INTERVAL_BASE_BITS - 1) + 4'(code);
	endfunction : intervalTap

	wit_pkg::wit_ctrl_s                  ctrl_ff;
	wit_pkg::wit_ctrl_s                  nxt_ctrl;
	logic [wit_pkg::DATA_WIDTH-1:0]      nxt_cpuRdData;
	logic [wit_pkg::COUNTER_WIDTH-1:0]   counter_ff;
	logic [wit_pkg::COUNTER_WIDTH-1:0]   nxt_counter;
	wit_pkg::wit_event_s                 events;
	logic                                fwTick;
	logic                                prescAdvance;
	logic                                prescClear;
	logic                                counterRunning;
	logic                                prescWrap;
	logic                                counterWrap;
	logic                                intervalLegal;
	logic [wit_pkg::PRESCALER_WIDTH-1:0] prescCount;
	logic [wit_pkg::PRESCALER_WIDTH-1:0] lowOnes;

	// Watch clock ticks from the main clock.
	wit_clock_divider u_divider
	(
		.clk              (clk),
		.srst             (srst),
		.countClockSelect (ctrl_ff.countClockSelect),
		.fwTick_ff        (fwTick)
	);

	// The prescaler runs whenever the timer is enabled.
	wit_prescaler u_prescaler
	(
		.clk      (clk),
		.srst     (srst),
		.clear    (prescClear),
		.advance  (prescAdvance),
		.count_ff (prescCount)
	);

	// Each lowOnes bit says the prescaler bits up to it are all ones.
	genvar gi;
	generate
		for (gi = 0; gi < wit_pkg::PRESCALER_WIDTH; gi++)
		begin : g_low_ones
			assign lowOnes[gi] = &prescCount[gi:0];
		end
	endgenerate

	// Control register: whole-byte writes, bit 2 held at zero.
	always_comb
	begin
		nxt_ctrl = ctrl_ff;
		if (cpuWrEn && isCtrlAddr(cpuAddr))
		begin
			nxt_ctrl              = wit_pkg::wit_ctrl_s'(cpuWrData);
			nxt_ctrl.reservedZero = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			ctrl_ff <= wit_pkg::wit_ctrl_s'(wit_pkg::WATCH_MODE_CONTROL_RESET);
		else
			ctrl_ff <= nxt_ctrl;
	end

	// Read data appears one cycle after the read strobe, zero otherwise.
	always_comb
	begin
		nxt_cpuRdData = '0;
		if (cpuRdEn && isCtrlAddr(cpuAddr))
			nxt_cpuRdData = ctrl_ff;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			cpuRdData_ff <= '0;
		else
			cpuRdData_ff <= nxt_cpuRdData;
	end

	// Prescaler control and watch counter.
	assign prescClear     = ~ctrl_ff.timerEnable;
	assign prescAdvance   = fwTick & ctrl_ff.timerEnable;
	assign counterRunning = ctrl_ff.timerEnable & ctrl_ff.counterRun;
	assign prescWrap      = prescAdvance & lowOnes[wit_pkg::PRESCALER_WIDTH-1];
	assign counterWrap    = counterRunning & prescWrap & (&counter_ff);

	always_comb
	begin
		if (!counterRunning)
			nxt_counter = '0;
		else if (prescWrap)
			nxt_counter = counter_ff + 1'b1;
		else
			nxt_counter = counter_ff;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			counter_ff <= '0;
		else
			counter_ff <= nxt_counter;
	end

	// Event decode; prohibited interval codes raise no interval event.
	assign intervalLegal = ctrl_ff.intervalSelect <= wit_pkg::INTERVAL_CODE_MAX;

	always_comb
	begin
		events = '0;
		if (ctrl_ff.flagRateSelect)
			events.watchEvent = counterRunning & prescAdvance
				& lowOnes[wit_pkg::FAST_FEED_BITS-1];
		else
			events.watchEvent = counterWrap;
		if (intervalLegal)
			events.intervalEvent = prescAdvance
				& lowOnes[intervalTap(ctrl_ff.intervalSelect)];
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			watchInterrupt_ff    <= 1'b0;
			intervalInterrupt_ff <= 1'b0;
		end
		else
		begin
			watchInterrupt_ff    <= events.watchEvent;
			intervalInterrupt_ff <= events.intervalEvent;
		end
	end

endmodule : wit_watch_timer

// ===== verification/wit_watch_timer_assertions.sv
// Port assertions for the watch and interval timer.
// Assumes the bind below and a synchronous active-high reset.
`timescale 1ns/1ps
module wit_watch_timer_assertions
(
	input wire logic        clk,
	input wire logic        srst,
	input wire logic [15:0] cpuAddr,
	input wire logic        cpuWrEn,
	input wire logic [7:0]  cpuWrData,
	input wire logic        cpuRdEn,
	input wire logic [7:0]  cpuRdData_ff,
	input wire logic        watchInterrupt_ff,
	input wire logic        intervalInterrupt_ff
);
	logic [7:0]  ctl_ff;
	logic [1:0]  age_ff;
	logic [20:0] iGap_ff;
	logic [20:0] wGap_ff;
	logic        iSeen_ff;
	logic        wSeen_ff;
	logic        wr;
	assign wr = cpuWrEn && cpuAddr == 16'hFF41;
	// Shadow of the control byte; gaps are trusted only from pulses made under it.
	always_ff @(posedge clk)
	begin
		if (srst || wr)
		begin
			ctl_ff   <= srst ? 8'h00 : (cpuWrData & 8'hFB);
			age_ff   <= 2'h0;
			iGap_ff  <= 21'h0;
			wGap_ff  <= 21'h0;
			iSeen_ff <= 1'b0;
			wSeen_ff <= 1'b0;
		end
		else
		begin
			age_ff   <= age_ff + {1'b0, age_ff != 2'h3};
			iGap_ff  <= intervalInterrupt_ff ? 21'h0 : iGap_ff + 21'h1;
			wGap_ff  <= watchInterrupt_ff ? 21'h0 : wGap_ff + 21'h1;
			iSeen_ff <= iSeen_ff || (intervalInterrupt_ff && age_ff == 2'h3);
			wSeen_ff <= wSeen_ff || (watchInterrupt_ff && age_ff == 2'h3);
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	idle_read_zero_a: assert property (!cpuRdEn |=> cpuRdData_ff == 8'h00)
		else $error("read data not zero");
	read_back_a: assert property (cpuRdEn && cpuAddr == 16'hFF41 |=> cpuRdData_ff == $past(ctl_ff))
		else $error("control read wrong");
	unmapped_read_a: assert property (cpuRdEn && cpuAddr != 16'hFF41 |=> cpuRdData_ff == 8'h00)
		else $error("unmapped read not zero");
	interval_single_a: assert property (intervalInterrupt_ff |=> !intervalInterrupt_ff)
		else $error("interval pulse too long");
	watch_single_a: assert property (watchInterrupt_ff |=> !watchInterrupt_ff)
		else $error("watch pulse too long");
	interval_gated_a: assert property (age_ff == 2'h3 && (!ctl_ff[0] || ctl_ff[6:4] > 3'h5) |-> !intervalInterrupt_ff)
		else $error("interval pulse while off");
	watch_gated_a: assert property (age_ff == 2'h3 && !(ctl_ff[0] && ctl_ff[1]) |-> !watchInterrupt_ff)
		else $error("watch pulse while off");
	interval_period_a: assert property (intervalInterrupt_ff && iSeen_ff |-> iGap_ff == ((ctl_ff[7] ? 21'h800 : 21'h80) << ({1'b0, ctl_ff[6:4]} + 4'h4)) - 21'h1)
		else $error("interval period wrong");
	fast_watch_period_a: assert property (watchInterrupt_ff && wSeen_ff && ctl_ff[3] |-> wGap_ff == ((ctl_ff[7] ? 21'h800 : 21'h80) << 5) - 21'h1)
		else $error("fast watch period wrong");
endmodule : wit_watch_timer_assertions

bind wit_watch_timer wit_watch_timer_assertions u_wit_watch_timer_assertions (.clk(clk), .srst(srst), .cpuAddr(cpuAddr), .cpuWrEn(cpuWrEn), .cpuWrData(cpuWrData), .cpuRdEn(cpuRdEn), .cpuRdData_ff(cpuRdData_ff), .watchInterrupt_ff(watchInterrupt_ff), .intervalInterrupt_ff(intervalInterrupt_ff));

// ===== verification/wit_watch_timer_tb_top.sv
// Self-checking bench for the watch and interval timer.
// Assumes the package is compiled first; inputs change at falling edges.
`timescale 1ns/1ps
module wit_watch_timer_tb_top;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [15:0] cpuAddr = 16'h0000;
	logic        cpuWrEn = 1'b0;
	logic [7:0]  cpuWrData = 8'h00;
	logic        cpuRdEn = 1'b0;
	logic [7:0]  cpuRdData_ff;
	logic        watchInterrupt_ff;
	logic        intervalInterrupt_ff;
	int          failures = 0;
	int          compares = 0;
	int          cycles = 0;
	int          k;
	logic [31:0] n;
	logic [7:0]  d;
	logic [15:0] a;
	always #5 clk = ~clk;
	wit_watch_timer u_wit_watch_timer (.clk(clk), .srst(srst), .cpuAddr(cpuAddr),
		.cpuWrEn(cpuWrEn), .cpuWrData(cpuWrData), .cpuRdEn(cpuRdEn), .cpuRdData_ff(cpuRdData_ff),
		.watchInterrupt_ff(watchInterrupt_ff), .intervalInterrupt_ff(intervalInterrupt_ff));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	task automatic wrap_up;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	task automatic wr(input logic [7:0] v);
		cpuAddr = 16'hFF41;
		cpuWrData = v;
		cpuWrEn = 1'b1;
		@(negedge clk);
		cpuWrEn = 1'b0;
		@(negedge clk);
	endtask : wr
	task automatic rd(input logic [15:0] adr, output logic [31:0] v);
		cpuAddr = adr;
		cpuRdEn = 1'b1;
		@(negedge clk);
		v = {24'h0, cpuRdData_ff};
		cpuRdEn = 1'b0;
		@(negedge clk);
	endtask : rd
	// Counts falling edges until the chosen pulse is seen or the limit runs out.
	task automatic gap(input logic w, input int lim, output int c);
		c = 0;
		do
		begin
			@(negedge clk);
			c++;
		end
		while ((w ? watchInterrupt_ff : intervalInterrupt_ff) !== 1'b1 && c < lim);
	endtask : gap
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 32'h15F90)
		begin
			failures++;
			wrap_up();
		end
	end
	initial
	begin
		void'($urandom(15));
		repeat (16) @(negedge clk);
		srst = 1'b0;
		rd(16'hFF41, n);
		check("reset value", n, 32'h0);
		for (int i = 0; i < 6; i++)
		begin
			d = $urandom;
			a = $urandom;
			a = (a == 16'hFF41) ? 16'hFF40 : a;
			wr(d);
			rd(16'hFF41, n);
			check("control read", n, {24'h0, d & 8'hFB});
			rd(a, n);
			check("unmapped read", n, 32'h0);
		end
		for (int c = 0; c < 2; c++)
		begin
			wr(8'h00);
			wr({1'b0, c[2:0], 4'h1});
			gap(1'b0, 32'h4000, k);
			gap(1'b0, 32'h4000, k);
			check("interval period", k, 32'h80 << (c + 4));
		end
		wr(8'h00);
		gap(1'b0, 32'h1000, k);
		check("interval while stopped", k, 32'h1000);
		wr(8'h71);
		gap(1'b0, 32'h1000, k);
		check("prohibited code", k, 32'h1000);
		wr(8'h09);
		gap(1'b1, 32'h2000, k);
		check("watch while held", k, 32'h2000);
		gap(1'b0, 32'h1000, k);
		gap(1'b0, 32'h1000, k);
		check("interval while held", k, 32'h800);
		wr(8'h0B);
		gap(1'b1, 32'h4000, k);
		gap(1'b1, 32'h4000, k);
		check("fast watch period", k, 32'h1000);
		wr(8'h00);
		wr(8'h81);
		gap(1'b0, 32'h10000, k);
		check("slow first interval", {31'h0, k > 32'h7700 && k < 32'h8100}, 32'h1);
		wrap_up();
	end
endmodule : wit_watch_timer_tb_top
